/* core/hccs_cmd_status.sv */
// command and status register of the full/low speed host controller
// Contract
// - two-bit overrun count starts at zero, steps per overrun, wraps
// - count steps even when the interrupt overrun flag is already set
// - ownership request set raises the ownership change event
// - after changeover the ownership request clears until next request
// - at bulk head skip if filled zero, else process and clear
// - bulk descriptor found sets filled again; zero at end stops
// - at control head skip if filled zero, else process and clear
// - control descriptor found sets filled again; zero at end stops
// - writing controller reset starts reset into the suspended state
// - software reset clears registers but keeps exceptions; no bus access
// - reset finishes within the time limit and clears the bit itself
// - controller reset does not reset root hub or drive port resets
// - writes set one bits, leave zero bits; reads return all bits
// - periodic list unfinished at frame end steps count and sets flag
`timescale 1ns/1ps
module hccs_cmd_status
  import hccs_pkg::*;
#(
  parameter int RESET_CYCLES = HCCS_RESET_CYCLES
)(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic periodic_overrun,
  input wire logic bulk_head,
  input wire logic bulk_td_found,
  input wire logic bulk_done,
  input wire logic ctrl_head,
  input wire logic ctrl_td_found,
  input wire logic ctrl_done,
  input wire logic changeover_done,
  output logic bulk_active,
  output logic ctrl_active,
  output logic overrun_flag_set,
  output logic ownership_change_event_set,
  output logic sw_reset_active,
  output logic sw_reset_pulse,
  output logic enter_suspended_state,
  output logic host_bus_block
);
  typedef enum logic [1:0] {
    HCCS_IDLE = 2'b01,
    HCCS_RESET = 2'b10
  } hccs_state_t;

  hccs_state_t state_q;
  hccs_state_t state_d;
  logic [HCCS_RST_CNT_W-1:0] rst_cnt_q;
  logic [HCCS_RST_CNT_W-1:0] rst_cnt_d;
  logic [HCCS_OVR_CNT_W-1:0] ovr_cnt_q;
  logic [HCCS_OVR_CNT_W-1:0] ovr_cnt_d;
  logic ownership_change_request_q;
  logic ownership_change_request_d;
  logic bulk_list_filled_q;
  logic bulk_list_filled_d;
  logic control_list_filled_q;
  logic control_list_filled_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] status_w;

  hccs_list_if bulk_if();
  hccs_list_if ctrl_if();

  function automatic logic wr_bit(input logic [31:0] d, input int pos);
    return d[pos];
  endfunction

  wire logic sel_w = (reg_addr == HCCS_CMD_STATUS_OFS);
  // bus writes are dropped while the software reset runs
  wire logic wr_w = reg_wr && sel_w && (state_q == HCCS_IDLE);
  wire logic rst_start_w = wr_w && wr_bit(reg_wdata, HCCS_CTRL_RESET_BIT);
  wire logic rst_end_w = (state_q == HCCS_RESET) &&
    (rst_cnt_q == HCCS_RST_CNT_W'(RESET_CYCLES - 1));
  wire logic in_reset_w = (state_q == HCCS_RESET);

  assign bulk_if.head = bulk_head && !in_reset_w;
  assign bulk_if.td_found = bulk_td_found && !in_reset_w;
  assign bulk_if.list_done = bulk_done || in_reset_w;
  assign bulk_if.filled = bulk_list_filled_q;
  assign ctrl_if.head = ctrl_head && !in_reset_w;
  assign ctrl_if.td_found = ctrl_td_found && !in_reset_w;
  assign ctrl_if.list_done = ctrl_done || in_reset_w;
  assign ctrl_if.filled = control_list_filled_q;

  hccs_list_track u_bulk (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .lst(bulk_if)
  );
  hccs_list_track u_ctrl (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .lst(ctrl_if)
  );

  always_comb begin
    state_d = state_q;
    rst_cnt_d = rst_cnt_q;
    unique case (state_q)
      HCCS_IDLE: begin
        rst_cnt_d = '0;
        if (rst_start_w) begin
          state_d = HCCS_RESET;
        end
      end
      HCCS_RESET: begin
        rst_cnt_d = rst_cnt_q + HCCS_RST_CNT_W'(1);
        if (rst_end_w) begin
          state_d = HCCS_IDLE;
        end
      end
      default: begin
        state_d = HCCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= HCCS_IDLE;
      rst_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      rst_cnt_q <= rst_cnt_d;
    end
  end

  // next-value terms of the bank, one named wire each
  wire logic ovr_step_w = periodic_overrun;
  wire logic own_set_w = wr_w && wr_bit(reg_wdata, HCCS_OWN_REQ_BIT);
  wire logic own_clr_w = changeover_done;
  wire logic bulk_wr_w = wr_w && wr_bit(reg_wdata, HCCS_BULK_FILLED_BIT);
  wire logic bulk_set_w = bulk_wr_w || bulk_if.set_filled;
  wire logic bulk_clr_w = bulk_if.clear_filled;
  wire logic ctrl_wr_w = wr_w && wr_bit(reg_wdata, HCCS_CTRL_FILLED_BIT);
  wire logic ctrl_set_w = ctrl_wr_w || ctrl_if.set_filled;
  wire logic ctrl_clr_w = ctrl_if.clear_filled;
  wire logic rd_hit_w = reg_rd && sel_w;
  wire logic rd_miss_w = reg_rd && !sel_w;

  always_comb begin
    ovr_cnt_d = ovr_cnt_q;
    if (in_reset_w) begin
      ovr_cnt_d = HCCS_OVR_CNT_RST;
    end else if (ovr_step_w) begin
      ovr_cnt_d = ovr_cnt_q + HCCS_OVR_CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ovr_cnt_q <= HCCS_OVR_CNT_RST;
    end else begin
      ovr_cnt_q <= ovr_cnt_d;
    end
  end

  // cleared after changeover, new request wins
  always_comb begin
    ownership_change_request_d = ownership_change_request_q;
    if (in_reset_w) begin
      ownership_change_request_d = HCCS_CMD_STATUS_RST[HCCS_OWN_REQ_BIT];
    end else if (own_set_w) begin
      ownership_change_request_d = 1'b1;
    end else if (own_clr_w) begin
      ownership_change_request_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ownership_change_request_q <= HCCS_CMD_STATUS_RST[HCCS_OWN_REQ_BIT];
    end else begin
      ownership_change_request_q <= ownership_change_request_d;
    end
  end

  // bulk set by write or refill, set beats clear
  always_comb begin
    bulk_list_filled_d = bulk_list_filled_q;
    if (in_reset_w) begin
      bulk_list_filled_d = HCCS_CMD_STATUS_RST[HCCS_BULK_FILLED_BIT];
    end else if (bulk_set_w) begin
      bulk_list_filled_d = 1'b1;
    end else if (bulk_clr_w) begin
      bulk_list_filled_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bulk_list_filled_q <= HCCS_CMD_STATUS_RST[HCCS_BULK_FILLED_BIT];
    end else begin
      bulk_list_filled_q <= bulk_list_filled_d;
    end
  end

  // control set by write or refill, set beats clear
  always_comb begin
    control_list_filled_d = control_list_filled_q;
    if (in_reset_w) begin
      control_list_filled_d = HCCS_CMD_STATUS_RST[HCCS_CTRL_FILLED_BIT];
    end else if (ctrl_set_w) begin
      control_list_filled_d = 1'b1;
    end else if (ctrl_clr_w) begin
      control_list_filled_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      control_list_filled_q <= HCCS_CMD_STATUS_RST[HCCS_CTRL_FILLED_BIT];
    end else begin
      control_list_filled_q <= control_list_filled_d;
    end
  end

  always_comb begin
    status_w = HCCS_CMD_STATUS_RST;
    status_w[HCCS_CTRL_RESET_BIT] = in_reset_w;
    status_w[HCCS_CTRL_FILLED_BIT] = control_list_filled_q;
    status_w[HCCS_BULK_FILLED_BIT] = bulk_list_filled_q;
    status_w[HCCS_OWN_REQ_BIT] = ownership_change_request_q;
    status_w[HCCS_OVR_CNT_LSB +: HCCS_OVR_CNT_W] = ovr_cnt_q;
  end

  // read data holds until the next read strobe
  always_comb begin
    rdata_d = rdata_q;
    if (rd_hit_w) begin
      rdata_d = status_w;
    end else if (rd_miss_w) begin
      rdata_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_q <= HCCS_CMD_STATUS_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;

  logic own_req_prev_q;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      own_req_prev_q <= 1'b0;
    end else begin
      own_req_prev_q <= ownership_change_request_q;
    end
  end
  assign ownership_change_event_set =
    ownership_change_request_q && !own_req_prev_q;

  assign overrun_flag_set = periodic_overrun && !in_reset_w;

  // no root hub or port reset output exists
  assign sw_reset_active = in_reset_w;
  assign sw_reset_pulse = rst_start_w;
  assign enter_suspended_state = rst_end_w;
  assign host_bus_block = in_reset_w;
  assign bulk_active = bulk_if.active;
  assign ctrl_active = ctrl_if.active;
endmodule

/* core/hccs_list_if.sv */
// list processing handshake between the register bank and list trackers
`timescale 1ns/1ps
interface hccs_list_if;
  logic head;
  logic td_found;
  logic list_done;
  logic filled;
  logic clear_filled;
  logic set_filled;
  logic active;
  modport tracker (
    input head, input td_found, input list_done, input filled,
    output clear_filled, output set_filled, output active
  );
  modport bank (
    output head, output td_found, output list_done, output filled,
    input clear_filled, input set_filled, input active
  );
endinterface

/* core/hccs_list_track.sv */
// tracks processing of one non-periodic list against its filled bit
`timescale 1ns/1ps
module hccs_list_track
  import hccs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  hccs_list_if.tracker lst
);
  logic active_q;
  logic active_d;
  wire logic start_w = lst.head && lst.filled;
  assign lst.clear_filled = start_w;
  assign lst.set_filled = active_q && lst.td_found;
  always_comb begin
    active_d = active_q;
    if (start_w) begin
      active_d = 1'b1;
    end else if (lst.list_done) begin
      active_d = 1'b0;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active_d;
    end
  end
  assign lst.active = active_q;
endmodule

/* core/hccs_pkg.sv */
// package with offsets, field positions, reset values and timing counts
package hccs_pkg;
  localparam logic [7:0] HCCS_CMD_STATUS_OFS = 8'h08;
  localparam int HCCS_CTRL_RESET_BIT = 0;
  localparam int HCCS_CTRL_FILLED_BIT = 1;
  localparam int HCCS_BULK_FILLED_BIT = 2;
  localparam int HCCS_OWN_REQ_BIT = 3;
  localparam int HCCS_OVR_CNT_LSB = 16;
  localparam int HCCS_OVR_CNT_W = 2;
  localparam logic [31:0] HCCS_CMD_STATUS_RST = 32'h0000_0000;
  localparam logic [1:0] HCCS_OVR_CNT_RST = 2'h0;
  // controller reset must finish within this many nanoseconds
  localparam int HCCS_RESET_MAX_NS = 10000;
  localparam int HCCS_CLK_PERIOD_NS = 4;
  localparam int HCCS_RESET_CYCLES = HCCS_RESET_MAX_NS / HCCS_CLK_PERIOD_NS;
  localparam int HCCS_RST_CNT_W = 12;
endpackage

/* tb/hc_command_status_tb_top.sv */
// self-checking bench for the command and status register
`timescale 1ns/1ps
module hc_command_status_tb_top;
  localparam int RC = 8;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, cnt_exp, b;
  logic [7:0] ev = 8'h00;
  logic [1:0] act;
  logic ovf, own_ev, rst_act, rst_pls, susp, blk, rd_seen = 1'b0;
  logic [63:0] exp_q[$];
  logic [63:0] ent;
  int num_errors = 0, tests_run = 0, cyc = 0, n;
  int own_n = 0, rst_n = 0, act_n = 0, susp_n = 0;
  hccs_cmd_status #(.RESET_CYCLES(RC)) u_dut (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .periodic_overrun(ev[0]), .bulk_head(ev[1]), .ctrl_head(ev[2]),
    .bulk_td_found(ev[3]), .ctrl_td_found(ev[4]), .bulk_done(ev[5]),
    .ctrl_done(ev[6]), .changeover_done(ev[7]), .bulk_active(act[0]),
    .ctrl_active(act[1]), .overrun_flag_set(ovf),
    .ownership_change_event_set(own_ev), .sw_reset_active(rst_act),
    .sw_reset_pulse(rst_pls), .enter_suspended_state(susp),
    .host_bus_block(blk));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g,
                     logic [31:0] m = 32'hFFFF_FFFF);
    tests_run++;
    if ((g & m) !== (e & m)) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  // read noted in the queue; the watcher compares it one cycle later
  task automatic rd(logic [7:0] a, logic [31:0] e,
                    logic [31:0] m = 32'hFFFF_FFFF);
    @(negedge ref_clk);
    exp_q.push_back({m, e});
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
  endtask
  task automatic pulse(int k, logic [31:0] f = 32'h0);
    @(negedge ref_clk);
    ev[k] = 1'b1;
    #1 if (k == 0) chk("ovf", f, {31'h0, ovf});
    @(negedge ref_clk);
    ev[k] = 1'b0;
  endtask
  always @(posedge ref_clk) begin
    rd_seen <= reg_rd;
    cyc <= cyc + 1;
    own_n <= own_n + int'(own_ev);
    rst_n <= rst_n + int'(rst_pls);
    act_n <= act_n + int'(rst_act);
    susp_n <= susp_n + int'(susp);
    if (rd_seen) begin
      ent = exp_q.pop_front();
      chk("rdata", ent[31:0], reg_rdata, ent[63:32]);
    end
    if (cyc == 2000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(28));
    repeat (16) @(negedge ref_clk);
    sys_rst = 1'b0;
    wr(8'h0C, 32'hE);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    n = $urandom_range(9, 4);
    for (int i = 0; i < n; i++) pulse(0, 32'h1);
    cnt_exp = 32'(n % 4) << 16;
    rd(8'h08, cnt_exp);
    for (int i = 0; i < 2; i++) begin
      b = 32'h1 << (2 - i);
      wr(8'h08, b);
      rd(8'h08, cnt_exp | b);
      pulse(1 + i);
      chk("active", 32'h1, {31'h0, act[i]});
      rd(8'h08, cnt_exp);
      pulse(3 + i);
      rd(8'h08, cnt_exp | b);
      pulse(5 + i);
      chk("stop", 32'h0, {31'h0, act[i]});
      pulse(1 + i);
      pulse(5 + i);
      pulse(1 + i);
      chk("skip", 32'h0, {31'h0, act[i]});
    end
    wr(8'h08, 32'h4);
    wr(8'h08, 32'h8);
    repeat (3) @(negedge ref_clk);
    chk("own_ev", 32'h1, own_n);
    rd(8'h08, cnt_exp | 32'hC);
    pulse(7);
    rd(8'h08, cnt_exp | 32'h4);
    wr(8'h08, 32'h1);
    rd(8'h08, 32'h1, 32'h1);
    chk("blk", 32'h1, {31'h0, blk});
    wr(8'h08, 32'h4);
    pulse(0, 32'h0);
    repeat (RC) @(negedge ref_clk);
    chk("rst_len", RC, act_n);
    chk("blk_end", 32'h0, {31'h0, blk});
    chk("rst_pls", 32'h1, rst_n);
    chk("suspend", 32'h1, susp_n);
    rd(8'h08, 32'h0);
    repeat (2) @(negedge ref_clk);
    wrap_up();
  end
endmodule

/* tb/hccs_cmd_status_checker.sv */
// assertion checker for the command and status register
`timescale 1ns/1ps
module hccs_cmd_status_checker #(
  parameter int RESET_CYCLES = 8
)(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic periodic_overrun,
  input wire logic bulk_head,
  input wire logic bulk_done,
  input wire logic bulk_active,
  input wire logic overrun_flag_set,
  input wire logic ownership_change_event_set,
  input wire logic sw_reset_active,
  input wire logic sw_reset_pulse,
  input wire logic enter_suspended_state,
  input wire logic host_bus_block
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire hit = reg_wr && reg_addr == 8'h08;
  wire own_wr = hit && reg_wdata[3] && !sw_reset_active;
  wire stop_src = bulk_done || sw_reset_active;
  sequence s_last_cycle;
    sw_reset_active ##1 !sw_reset_active;
  endsequence
  a_overrun_flag: assert property (
    overrun_flag_set == (periodic_overrun && !sw_reset_active))
    else $error("overrun flag does not follow overrun input");
  a_reset_cause: assert property (
    sw_reset_pulse |-> hit && reg_wdata[0] && !sw_reset_active)
    else $error("reset pulse without reset write");
  a_reset_start: assert property (sw_reset_pulse |=> sw_reset_active)
    else $error("reset did not start");
  a_bus_block: assert property (host_bus_block == sw_reset_active)
    else $error("bus block differs from reset state");
  a_reset_bound: assert property (
    $rose(sw_reset_active) |-> ##[1:RESET_CYCLES] !sw_reset_active)
    else $error("reset too long");
  a_suspend_end: assert property (enter_suspended_state |-> s_last_cycle)
    else $error("suspend entry not in last reset cycle");
  a_own_event: assert property (
    ownership_change_event_set |-> $past(own_wr) || $past(own_wr, 2))
    else $error("ownership event without request");
  a_bulk_start: assert property ($rose(bulk_active) |-> $past(bulk_head))
    else $error("bulk processing started without head");
  a_bulk_stop: assert property ($fell(bulk_active) |-> $past(stop_src))
    else $error("bulk processing stopped without end of list");
  a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data changed without a read");
endmodule
bind hccs_cmd_status hccs_cmd_status_checker #(.RESET_CYCLES(RESET_CYCLES))
  u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .periodic_overrun(periodic_overrun),
  .bulk_head(bulk_head), .bulk_done(bulk_done), .bulk_active(bulk_active),
  .overrun_flag_set(overrun_flag_set), .sw_reset_active(sw_reset_active),
  .ownership_change_event_set(ownership_change_event_set),
  .sw_reset_pulse(sw_reset_pulse), .host_bus_block(host_bus_block),
  .enter_suspended_state(enter_suspended_state));
